// File: rtl/sarm_pkg.sv
package sarm_pkg;
  // Channel count; register indices below are laid out for two channels
  localparam int NCH = 2;
  // Word indices; byte address is four times the index
  localparam logic [5:0] IDX_CTRL_B [NCH] = '{6'h0a, 6'h01};
  localparam logic [5:0] IDX_STAT_A [NCH] = '{6'h0b, 6'h02};
  localparam logic [5:0] IDX_DATA [NCH] = '{6'h0c, 6'h03};
  localparam logic [5:0] IDX_BAUD [NCH] = '{6'h0d, 6'h04};
  // Control B layout and reset
  localparam logic [7:0] CTRL_B_RST = 8'h02;
  localparam logic [7:0] CTRL_B_WMASK = 8'hfd;
  localparam int CB_RXCIE = 7;
  localparam int CB_TXCIE = 6;
  localparam int CB_UDRIE = 5;
  localparam int CB_RXEN = 4;
  localparam int CB_TXEN = 3;
  localparam int CB_NINE = 2;
  localparam int CB_RX9 = 1;
  localparam int CB_TX9 = 0;
  // Status A layout
  localparam int SA_RXC = 7;
  localparam int SA_TXC = 6;
  localparam int SA_UDRE = 5;
  localparam int SA_FE = 4;
  localparam int SA_OR = 3;
  localparam int SA_U2X = 1;
  localparam int SA_MPCM = 0;
  // Baud divider reset: one sample tick per clock
  localparam logic [7:0] BAUD_RST = 8'h00;
  // Sample counts per bit (index of last sample) and first vote sample
  localparam logic [3:0] LAST_NORM = 4'hf;
  localparam logic [3:0] LAST_DBL = 4'h7;
  localparam logic [3:0] VOTE_NORM = 4'h7;
  localparam logic [3:0] VOTE_DBL = 4'h3;
  // Data bit index of the last data bit
  localparam logic [3:0] RX_LAST8 = 4'h7;
  localparam logic [3:0] RX_LAST9 = 4'h8;
  // Total bits per transmitted frame
  localparam logic [3:0] TX_BITS8 = 4'ha;
  localparam logic [3:0] TX_BITS9 = 4'hb;
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b11,
    RX_STOP = 2'b10
  } sarm_rx_e;
endpackage

// File: rtl/sarm_top.sv
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module sarm_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic global_irq_en,
  input wire logic [sarm_pkg::NCH-1:0] serial_rx_pin,
  output logic [sarm_pkg::NCH-1:0] serial_tx_pin,
  output logic [sarm_pkg::NCH-1:0] rx_done_irq,
  output logic [sarm_pkg::NCH-1:0] tx_done_irq,
  output logic [sarm_pkg::NCH-1:0] tx_empty_irq
);
  import sarm_pkg::*;

  // Software-visible registers per channel, and the baud down-counter div_r
  logic [7:0] ctrl_r [NCH], ctrl_nxt [NCH];
  logic [7:0] baud_r [NCH], baud_nxt [NCH];
  logic [7:0] div_r [NCH], div_nxt [NCH];
  logic [7:0] rxd_r [NCH], rxd_nxt [NCH];
  logic [7:0] txh_r [NCH], txh_nxt [NCH];
  // Shifters, sample counters and vote history
  logic [8:0] rsh_r [NCH], rsh_nxt [NCH];
  logic [10:0] tsh_r [NCH], tsh_nxt [NCH];
  logic [3:0] rsc_r [NCH], rsc_nxt [NCH];
  logic [3:0] rbit_r [NCH], rbit_nxt [NCH];
  logic [3:0] tsc_r [NCH], tsc_nxt [NCH];
  logic [3:0] tbit_r [NCH], tbit_nxt [NCH];
  logic [1:0] vote_r [NCH], vote_nxt [NCH];
  // Pin synchroniser and receiver state
  logic [1:0] sync_r [NCH];
  sarm_rx_e rst_r [NCH], rst_nxt [NCH];
  // Status flags, modes and registered requests
  logic [NCH-1:0] rxc_r, rxc_nxt, txc_r, txc_nxt, udre_r, udre_nxt;
  logic [NCH-1:0] fe_r, fe_nxt, or_r, or_nxt, orp_r, orp_nxt;
  logic [NCH-1:0] u2x_r, u2x_nxt, mpcm_r, mpcm_nxt, tbusy_r, tbusy_nxt;
  logic [NCH-1:0] txo_r, txo_nxt, rxi_r, rxi_nxt, txi_r, txi_nxt, udi_r, udi_nxt;
  // Bus data-phase state and response
  logic wact_r, wact_nxt;
  logic [5:0] widx_r, widx_nxt;
  logic [31:0] hrdata_r, hrdata_nxt;
  logic a_act;
  logic hreadyout_r, hresp_r;

  // Outputs straight from registers
  assign hreadyout = hreadyout_r;
  assign hresp = hresp_r;
  assign hrdata = hrdata_r;
  assign serial_tx_pin = txo_r;
  assign rx_done_irq = rxi_r;
  assign tx_done_irq = txi_r;
  assign tx_empty_irq = udi_r;
  assign a_act = hsel & hready & htrans[1];

  // Two-stage synchroniser on each receive pin
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int c = 0; c < NCH; c++) begin
        sync_r[c] <= 2'b11;
      end
    end else begin
      for (int c = 0; c < NCH; c++) begin
        sync_r[c] <= {sync_r[c][0], serial_rx_pin[c]};
      end
    end
  end

  // Next state of bus slave, registers, receivers and transmitters
  always_comb begin
    logic tick;
    logic rx_s;
    logic maj;
    logic done;
    logic nine;
    logic is_addr;
    logic wr_data;
    logic [3:0] last;
    logic [3:0] v0;
    tick = 1'b0;
    rx_s = 1'b1;
    maj = 1'b0;
    done = 1'b0;
    nine = 1'b0;
    is_addr = 1'b0;
    wr_data = 1'b0;
    last = LAST_NORM;
    v0 = VOTE_NORM;
    wact_nxt = a_act & hwrite;
    widx_nxt = haddr[7:2];
    hrdata_nxt = 32'h0;
    // Per-bit outputs default to idle line, no requests
    txo_nxt = '1;
    rxi_nxt = '0;
    txi_nxt = '0;
    udi_nxt = '0;
    ctrl_nxt = ctrl_r;
    baud_nxt = baud_r;
    div_nxt = div_r;
    rxd_nxt = rxd_r;
    txh_nxt = txh_r;
    rsh_nxt = rsh_r;
    tsh_nxt = tsh_r;
    rsc_nxt = rsc_r;
    rbit_nxt = rbit_r;
    tsc_nxt = tsc_r;
    tbit_nxt = tbit_r;
    vote_nxt = vote_r;
    rst_nxt = rst_r;
    rxc_nxt = rxc_r;
    txc_nxt = txc_r;
    udre_nxt = udre_r;
    fe_nxt = fe_r;
    or_nxt = or_r;
    orp_nxt = orp_r;
    u2x_nxt = u2x_r;
    mpcm_nxt = mpcm_r;
    tbusy_nxt = tbusy_r;
    for (int c = 0; c < NCH; c++) begin
      // Shared sample tick from the baud divider
      tick = (div_r[c] == 8'h00);
      div_nxt[c] = tick ? baud_r[c] : div_r[c] - 8'h01;
      // Bit length and vote position follow speed select
      last = u2x_r[c] ? LAST_DBL : LAST_NORM;
      v0 = u2x_r[c] ? VOTE_DBL : VOTE_NORM;
      nine = ctrl_r[c][CB_NINE];
      // Only the second synchroniser stage feeds logic
      rx_s = sync_r[c][1];
      done = 1'b0;
      maj = 1'b0;
      // Register writes in the data phase
      wr_data = wact_r && (widx_r == IDX_DATA[c]);
      if (wact_r && (widx_r == IDX_CTRL_B[c])) begin
        ctrl_nxt[c] = (hwdata[7:0] & CTRL_B_WMASK) | (ctrl_r[c] & ~CTRL_B_WMASK);
      end
      // Status write: modes, write one clears transmit done
      if (wact_r && (widx_r == IDX_STAT_A[c])) begin
        u2x_nxt[c] = hwdata[SA_U2X];
        mpcm_nxt[c] = hwdata[SA_MPCM];
        if (hwdata[SA_TXC]) begin
          txc_nxt[c] = 1'b0;
        end
      end
      // Data port write fills the holding register
      if (wr_data) begin
        txh_nxt[c] = hwdata[7:0];
        udre_nxt[c] = 1'b0;
      end
      // Baud divider reload value
      if (wact_r && (widx_r == IDX_BAUD[c])) begin
        baud_nxt[c] = hwdata[7:0];
      end
      // Reading the data port releases the byte and shows a held overrun
      if (a_act && !hwrite && (haddr[7:2] == IDX_DATA[c])) begin
        rxc_nxt[c] = 1'b0;
        or_nxt[c] = orp_r[c];
        orp_nxt[c] = 1'b0;
      end
      // Receiver
      if (!ctrl_r[c][CB_RXEN]) begin
        rst_nxt[c] = RX_IDLE;
      end else if (tick) begin
        case (rst_r[c])
          RX_IDLE: begin
            if (!rx_s) begin
              rst_nxt[c] = RX_START;
              rsc_nxt[c] = 4'h1;
            end
          end
          default: begin
            rsc_nxt[c] = (rsc_r[c] == last) ? 4'h0 : rsc_r[c] + 4'h1;
            // Sample count runs one below the sample number
            if ((rsc_r[c] == v0) || (rsc_r[c] == v0 + 4'h1)) begin
              vote_nxt[c] = {vote_r[c][0], rx_s};
            end
            if (rsc_r[c] == v0 + 4'h2) begin
              maj = (vote_r[c][1] & vote_r[c][0]) | ((vote_r[c][1] | vote_r[c][0]) & rx_s);
              case (rst_r[c])
                RX_START: begin
                  if (maj) begin
                    rst_nxt[c] = RX_IDLE;
                  end
                end
                RX_DATA: begin
                  rsh_nxt[c] = {maj, rsh_r[c][8:1]};
                end
                RX_STOP: begin
                  done = 1'b1;
                  rst_nxt[c] = RX_IDLE;
                end
                default: begin
                end
              endcase
            end
            // End of bit: next data bit or stop bit
            if (rsc_r[c] == last) begin
              if (rst_nxt[c] == RX_START) begin
                rst_nxt[c] = RX_DATA;
                rbit_nxt[c] = 4'h0;
              end else if (rst_r[c] == RX_DATA) begin
                if (rbit_r[c] == (nine ? RX_LAST9 : RX_LAST8)) begin
                  rst_nxt[c] = RX_STOP;
                end else begin
                  rbit_nxt[c] = rbit_r[c] + 4'h1;
                end
              end
            end
          end
        endcase
      end
      // Frame completion: address filter, transfer or overrun
      is_addr = nine ? rsh_r[c][8] : maj;
      if (done && !(mpcm_r[c] && !is_addr)) begin
        // Overrun keeps the older byte, drops the new one
        if (rxc_nxt[c]) begin
          orp_nxt[c] = 1'b1;
        end else begin
          rxd_nxt[c] = nine ? rsh_r[c][7:0] : rsh_r[c][8:1];
          if (nine) begin
            ctrl_nxt[c][CB_RX9] = rsh_r[c][8];
          end
          rxc_nxt[c] = 1'b1;
          fe_nxt[c] = ~maj;
          or_nxt[c] = 1'b0;
        end
      end
      // Transmitter
      if (tbusy_r[c]) begin
        if (tick) begin
          tsc_nxt[c] = (tsc_r[c] == last) ? 4'h0 : tsc_r[c] + 4'h1;
          if (tsc_r[c] == last) begin
            tsh_nxt[c] = {1'b1, tsh_r[c][10:1]};
            tbit_nxt[c] = tbit_r[c] - 4'h1;
            if (tbit_r[c] == 4'h1) begin
              tbusy_nxt[c] = 1'b0;
              if (udre_r[c] && ctrl_r[c][CB_RXEN]) begin
                txc_nxt[c] = 1'b1;
              end
            end
          end
        end
      end else if (ctrl_r[c][CB_TXEN] && !udre_r[c]) begin
        // Load start, data, ninth or extra stop, stop
        tsh_nxt[c] = {1'b1, nine ? ctrl_r[c][CB_TX9] : 1'b1, txh_r[c], 1'b0};
        tbit_nxt[c] = nine ? TX_BITS9 : TX_BITS8;
        tsc_nxt[c] = 4'h0;
        tbusy_nxt[c] = 1'b1;
        udre_nxt[c] = ~wr_data;
      end
      // Pin follows next shifter bit so it stays registered
      txo_nxt[c] = tbusy_nxt[c] ? tsh_nxt[c][0] : 1'b1;
      // Interrupt requests
      rxi_nxt[c] = rxc_r[c] & ctrl_r[c][CB_RXCIE] & global_irq_en;
      txi_nxt[c] = txc_r[c] & ctrl_r[c][CB_TXCIE] & global_irq_en;
      udi_nxt[c] = udre_r[c] & ctrl_r[c][CB_UDRIE] & global_irq_en;
      // Read data, taken from next values (data port from the held byte rxd_r) so a preceding write is seen
      if (a_act && !hwrite) begin
        if (haddr[7:2] == IDX_CTRL_B[c]) begin
          hrdata_nxt = {24'h0, ctrl_nxt[c]};
        end else if (haddr[7:2] == IDX_STAT_A[c]) begin
          hrdata_nxt = {24'h0, rxc_nxt[c], txc_nxt[c], udre_nxt[c], fe_nxt[c],
                        or_nxt[c], 1'b0, u2x_nxt[c], mpcm_nxt[c]};
        end else if (haddr[7:2] == IDX_DATA[c]) begin
          hrdata_nxt = {24'h0, rxd_r[c]};
        end else if (haddr[7:2] == IDX_BAUD[c]) begin
          hrdata_nxt = {24'h0, baud_nxt[c]};
        end
      end
    end
  end

  // State registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int c = 0; c < NCH; c++) begin
        ctrl_r[c] <= CTRL_B_RST;
        baud_r[c] <= BAUD_RST;
        div_r[c] <= BAUD_RST;
        rxd_r[c] <= 8'h00;
        txh_r[c] <= 8'h00;
        rsh_r[c] <= 9'h000;
        tsh_r[c] <= 11'h7ff;
        rsc_r[c] <= 4'h0;
        rbit_r[c] <= 4'h0;
        tsc_r[c] <= 4'h0;
        tbit_r[c] <= 4'h0;
        vote_r[c] <= 2'b00;
        rst_r[c] <= RX_IDLE;
      end
      // Flags, modes and outputs
      rxc_r <= '0;
      txc_r <= '0;
      udre_r <= '1;
      fe_r <= '0;
      or_r <= '0;
      orp_r <= '0;
      u2x_r <= '0;
      mpcm_r <= '0;
      tbusy_r <= '0;
      txo_r <= '1;
      rxi_r <= '0;
      txi_r <= '0;
      udi_r <= '0;
      wact_r <= 1'b0;
      widx_r <= 6'h00;
      hrdata_r <= 32'h0;
      // Bus never stalls or errors
      hreadyout_r <= 1'b1;
      hresp_r <= 1'b0;
    end else begin
      // Register all next values
      ctrl_r <= ctrl_nxt;
      baud_r <= baud_nxt;
      div_r <= div_nxt;
      rxd_r <= rxd_nxt;
      txh_r <= txh_nxt;
      rsh_r <= rsh_nxt;
      tsh_r <= tsh_nxt;
      rsc_r <= rsc_nxt;
      rbit_r <= rbit_nxt;
      tsc_r <= tsc_nxt;
      tbit_r <= tbit_nxt;
      vote_r <= vote_nxt;
      rst_r <= rst_nxt;
      rxc_r <= rxc_nxt;
      txc_r <= txc_nxt;
      udre_r <= udre_nxt;
      fe_r <= fe_nxt;
      or_r <= or_nxt;
      orp_r <= orp_nxt;
      u2x_r <= u2x_nxt;
      mpcm_r <= mpcm_nxt;
      tbusy_r <= tbusy_nxt;
      txo_r <= txo_nxt;
      rxi_r <= rxi_nxt;
      txi_r <= txi_nxt;
      udi_r <= udi_nxt;
      wact_r <= wact_nxt;
      widx_r <= widx_nxt;
      hrdata_r <= hrdata_nxt;
      // Bus never stalls or errors
      hreadyout_r <= 1'b1;
      hresp_r <= 1'b0;
    end
  end
endmodule

// File: bench/sarm_peer.sv
`timescale 1ns/1ps
// Far-end transmitter on one receive line
module sarm_peer (
  input wire logic clk,
  output logic line
);
  initial line = 1'b1;
  // Start, data LSB first, optional ninth, stop
  task automatic send(input logic [8:0] d, input logic nine, input logic stop, input int per);
    logic [10:0] f;
    f = nine ? {stop, d, 1'b0} : {1'b1, stop, d[7:0], 1'b0};
    for (int i = 0; i < (nine ? 11 : 10); i++) begin
      line <= f[i];
      repeat (per) @(posedge clk);
    end
    line <= 1'b1;
  endtask
  // Short low spike on an idle line
  task automatic pulse(input int n);
    line <= 1'b0;
    repeat (n) @(posedge clk);
    line <= 1'b1;
  endtask
endmodule

// File: bench/sarm_monitor.sv
`timescale 1ns/1ps
module sarm_monitor (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  input wire logic global_irq_en,
  input wire logic [1:0] serial_tx_pin,
  input wire logic [1:0] rx_done_irq,
  input wire logic [1:0] tx_done_irq,
  input wire logic [1:0] tx_empty_irq
);
  import sarm_pkg::*;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Read taken at a word index
  sequence rd_at(logic [5:0] i);
    hsel && hready && htrans[1] && !hwrite && haddr[7:2] == i;
  endsequence
  a_rsv_bit_zero: assert property (rd_at(IDX_STAT_A[0]) |=> !hrdata[2])
    else $error("status bit 2 read high");
  a_data_upper_zero: assert property (rd_at(IDX_DATA[0]) |=> hrdata[31:8] == 24'h0)
    else $error("data read upper bits set");
  a_unmapped_zero: assert property (rd_at(6'h3f) |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_rx_irq_gate: assert property (rx_done_irq[0] |-> $past(global_irq_en))
    else $error("rx irq without global enable");
  a_tx_irq_gate: assert property (tx_done_irq[0] |-> $past(global_irq_en))
    else $error("tx irq without global enable");
  a_empty_irq_gate: assert property (tx_empty_irq[0] |-> $past(global_irq_en))
    else $error("empty irq without global enable");
  a_rx_irq_drop: assert property (rd_at(IDX_DATA[0]) |-> ##2 !rx_done_irq[0])
    else $error("rx irq stays after data read");
  a_start_len: assert property ($fell(serial_tx_pin[0]) |-> !serial_tx_pin[0] [*8])
    else $error("start bit too short");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus wait or error");
endmodule
bind sarm_top sarm_monitor mon (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
  .hresp(hresp), .global_irq_en(global_irq_en), .serial_tx_pin(serial_tx_pin),
  .rx_done_irq(rx_done_irq), .tx_done_irq(tx_done_irq), .tx_empty_irq(tx_empty_irq));

// File: bench/tb.sv
`timescale 1ns/1ps
module tb;
  import sarm_pkg::*;
  localparam logic [5:0] C0 = IDX_CTRL_B[0];
  localparam logic [5:0] S0 = IDX_STAT_A[0];
  localparam logic [5:0] D0 = IDX_DATA[0];
  localparam logic [5:0] C1 = IDX_CTRL_B[1];
  localparam logic [5:0] S1 = IDX_STAT_A[1];
  localparam logic [5:0] D1 = IDX_DATA[1];
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic gie = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  wire [1:0] rxp;
  logic [1:0] txp, rxi, txi, tei;
  int fail_count = 0;
  int n_checks = 0;
  int cyc = 0;
  // Clock; channel 0 transmit loops into channel 1 receive
  always #10 hclk = ~hclk;
  assign rxp[1] = txp[0];
  sarm_peer peer (.clk(hclk), .line(rxp[0]));
  sarm_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .global_irq_en(gie), .serial_rx_pin(rxp),
    .serial_tx_pin(txp), .rx_done_irq(rxi), .tx_done_irq(txi), .tx_empty_irq(tei));
  // Hang guard
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fail_count++;
      test_done();
    end
  end
  // Verdict
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Compare
  task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    n_checks++;
    if (s !== e) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  // One bus transfer, address then data phase
  task automatic ahb(input logic w, input logic [5:0] i, input logic [7:0] d, output logic [7:0] r);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, i, 2'b00};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata[7:0];
  endtask
  task automatic wr(input logic [5:0] i, input logic [7:0] d);
    logic [7:0] x;
    ahb(1'b1, i, d, x);
  endtask
  task automatic rd(input string nm, input logic [5:0] i, input logic [7:0] e);
    logic [7:0] x;
    ahb(1'b0, i, 8'h00, x);
    chk(nm, x, e);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // Reset values, read-only bit, unmapped place
  task automatic t_reset;
    rd("ctrl0", C0, 8'h02);
    rd("ctrl1", C1, 8'h02);
    rd("stat0", S0, 8'h20);
    wr(C0, 8'h00);
    rd("ctrl0 ro", C0, 8'h02);
    wr(6'h3f, 8'hff);
    rd("unmapped", 6'h3f, 8'h00);
  endtask
  // Plain byte with interrupt
  task automatic t_rx;
    wr(C0, 8'h90);
    gie <= 1'b1;
    peer.send(9'h0a5, 1'b0, 1'b1, 16);
    idle(6);
    chk("rx irq", {7'h0, rxi[0]}, 8'h01);
    rd("stat rx", S0, 8'ha0);
    rd("data rx", D0, 8'ha5);
    rd("stat rd", S0, 8'h20);
  endtask
  // Spike high again by sample 8
  task automatic t_noise;
    peer.pulse(7);
    idle(170);
    rd("stat noise", S0, 8'h20);
  endtask
  // Address filtering in eight-bit frames
  task automatic t_mpcm;
    wr(S0, 8'h01);
    peer.send(9'h033, 1'b0, 1'b0, 16);
    idle(6);
    rd("stat skip", S0, 8'h21);
    peer.send(9'h0c3, 1'b0, 1'b1, 16);
    idle(6);
    rd("stat addr", S0, 8'ha1);
    rd("data addr", D0, 8'hc3);
    wr(S0, 8'h00);
    peer.send(9'h05a, 1'b0, 1'b0, 16);
    idle(6);
    rd("stat data", S0, 8'hb0);
    rd("data data", D0, 8'h5a);
  endtask
  // Unread byte meets a second one
  task automatic t_ovr;
    peer.send(9'h011, 1'b0, 1'b1, 16);
    idle(2);
    peer.send(9'h022, 1'b0, 1'b1, 16);
    idle(6);
    rd("stat ovr", S0, 8'ha0);
    rd("data ovr", D0, 8'h11);
    rd("stat ovr rd", S0, 8'h28);
    peer.send(9'h033, 1'b0, 1'b1, 16);
    idle(6);
    rd("stat ovr clr", S0, 8'ha0);
    rd("data next", D0, 8'h33);
  endtask
  // Eight clocks per bit
  task automatic t_dbl;
    wr(S0, 8'h02);
    peer.send(9'h069, 1'b0, 1'b1, 8);
    idle(6);
    rd("stat dbl", S0, 8'ha2);
    rd("data dbl", D0, 8'h69);
    wr(S0, 8'h00);
  endtask
  // Receiver off keeps flags, blocks framing flag
  task automatic t_off;
    peer.send(9'h044, 1'b0, 1'b1, 16);
    idle(6);
    wr(C0, 8'h00);
    rd("stat off", S0, 8'ha0);
    rd("data off", D0, 8'h44);
    peer.send(9'h077, 1'b0, 1'b0, 16);
    idle(6);
    rd("stat off fe", S0, 8'h20);
  endtask
  // Nine-bit loop from channel 0 to channel 1
  task automatic t_tx9;
    wr(C1, 8'h14);
    wr(D1, 8'hee);
    wr(C0, 8'h5c);
    wr(D0, 8'h3c);
    idle(230);
    rd("stat1", S1, 8'h80);
    rd("ctrl1 ninth", C1, 8'h14);
    rd("data1", D1, 8'h3c);
    chk("tx irq", {7'h0, txi[0]}, 8'h01);
    rd("stat0 txc", S0, 8'h60);
    wr(S0, 8'h40);
    rd("stat0 clr", S0, 8'h20);
    wr(C0, 8'h7c);
    idle(3);
    chk("empty irq", {7'h0, tei[0]}, 8'h01);
    gie <= 1'b0;
    idle(3);
    chk("empty irq off", {7'h0, tei[0]}, 8'h00);
    chk("ch1 idle", {4'h0, txp[1], rxi[1], txi[1], tei[1]}, 8'h08);
    wr(S1, 8'h01);
    wr(D0, 8'h5a);
    idle(230);
    rd("stat1 filt", S1, 8'h01);
  endtask
  // Main sequence
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_rx();
    t_noise();
    t_mpcm();
    t_ovr();
    t_dbl();
    t_off();
    t_tx9();
    test_done();
  end
endmodule
